// ### hdl/swrb_pkg.sv
// Constants for the single-wire read-byte and triplet engine.
// Assumes a 20 MHz core clock; slot timing comes from internal timers.
package swrb_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 20000000; // Core clock rate
	localparam real START_MAX_NS = 262.5; // Latest start of line activity
	// Longest time rounds down; at least one cycle
	localparam int START_CYC = (START_MAX_NS * CLK_HZ / 1.0e9) < 1.0 ? 1 :
		int'($floor(START_MAX_NS * CLK_HZ / 1.0e9));
	localparam real STD_SLOT_NS = 70000.0; // Standard slot period
	localparam real STD_LOW_NS = 6000.0; // Standard initial low
	localparam real STD_W0_NS = 60000.0; // Standard write-zero low time
	localparam real STD_SMP_NS = 15000.0; // Standard sample delay
	localparam real OD_SLOT_NS = 10000.0; // Overdrive slot period
	localparam real OD_LOW_NS = 1000.0; // Overdrive initial low
	localparam real OD_W0_NS = 7500.0; // Overdrive write-zero low time
	localparam real OD_SMP_NS = 2000.0; // Overdrive sample delay
	localparam int STD_SLOT_CYC = int'($ceil(STD_SLOT_NS * CLK_HZ / 1.0e9));
	localparam int STD_LOW_CYC = int'($ceil(STD_LOW_NS * CLK_HZ / 1.0e9));
	localparam int STD_W0_CYC = int'($ceil(STD_W0_NS * CLK_HZ / 1.0e9));
	localparam int STD_SMP_CYC = int'($ceil(STD_SMP_NS * CLK_HZ / 1.0e9));
	localparam int OD_SLOT_CYC = int'($ceil(OD_SLOT_NS * CLK_HZ / 1.0e9));
	localparam int OD_LOW_CYC = int'($ceil(OD_LOW_NS * CLK_HZ / 1.0e9));
	localparam int OD_W0_CYC = int'($ceil(OD_W0_NS * CLK_HZ / 1.0e9));
	localparam int OD_SMP_CYC = int'($ceil(OD_SMP_NS * CLK_HZ / 1.0e9));
	localparam int TW = 12; // Timer width
	// ----------------------------------------
	// Command codes and field positions
	// ----------------------------------------
	localparam logic [7:0] CMD_READ_BYTE = 8'h96;
	localparam logic [7:0] CMD_TRIPLET = 8'h78;
	localparam logic [7:0] CMD_SET_PTR = 8'he1; // Set read pointer
	localparam int PTR_SEL_BIT = 0; // Parameter bit that selects read data
	localparam int TRIP_SLOTS = 3; // Slots in a triplet
	localparam int DIR_BIT = 7; // Direction value bit in direction byte
	localparam int NBITS_BYTE = 8; // Slots in a read byte
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00; // W: [7:0] code, [15:8] parameter
	localparam logic [7:0] ADDR_CFG = 8'h04; // RW: config bits
	localparam logic [7:0] ADDR_STATUS = 8'h08; // R: status bits
	localparam logic [7:0] ADDR_RDATA = 8'h0c; // R: read data register
	localparam logic [7:0] ADDR_PTR = 8'h10; // R: read pointer
	localparam logic [7:0] ADDR_ACK = 8'h14; // R: last command acknowledge
	localparam int CFG_OD = 0; // Overdrive speed select
	localparam int CFG_APU = 1; // Active pullup enable
	localparam int CFG_SPU = 2; // Strong pullup enable (unused here)
	localparam int ST_BUSY = 0;
	localparam int ST_SBR = 5;
	localparam int ST_TSB = 6;
	localparam int ST_DIR = 7;
	localparam logic [1:0] PTR_STATUS = 2'h0;
	localparam logic [1:0] PTR_RDATA = 2'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		SW_IDLE = 4'h1,
		SW_WAIT = 4'h2,
		SW_SLOT = 4'h4,
		SW_DONE = 4'h8
	} swrb_state_t;
endpackage

// ### hdl/swrb_engine.sv
// Read-byte and triplet engine behind an AXI4-Lite register port.
// Assumes a single 20 MHz clock and an open-drain single-wire line whose
// level is resolved by the bench from the enable output.
// The line is open drain: line_out stays low and line_oe high pulls it.
`timescale 1ns/1ns
// Contract
// RULE_01 - Read-byte code makes eight read slots
// RULE_02 - Sampled bits stored in read data
// RULE_03 - Busy at read-byte code: refuse, ignore
// RULE_04 - Read byte done in eight slots
// RULE_05 - Read-byte line activity starts promptly
// RULE_06 - Pointer returns to status after command
// RULE_07 - Busy held eight slots for read
// RULE_08 - Overdrive and active pullup both apply
// RULE_09 - Triplet code makes two reads, one write
// RULE_10 - Both zero: direction bit picks write
// RULE_11 - Zero then one: write zero
// RULE_12 - One then zero: write one
// RULE_13 - Both one: still write one
// RULE_14 - Busy at triplet code: refuse both bytes
// RULE_15 - Triplet done in three slots
// RULE_16 - Triplet line activity starts promptly
// RULE_17 - Busy held three slots for triplet
// RULE_18 - First sample updates single bit result
// RULE_19 - Second sample updates second bit, direction
// RULE_20 - Direction value in bit seven only
// RULE_21 - Line bits travel least significant first
// RULE_22 - Slot timers chosen by speed setting
module swrb_engine #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe,
	output logic pullup_active
);
	// ----------------------------------------
	// State record
	// ----------------------------------------
	// Everything the block remembers lives in this one record, so the
	// reset value and the register update stay in a single place
	typedef struct packed {
		swrb_pkg::swrb_state_t st; // Sequencer state
		logic aw_got; // Write address held
		logic w_got; // Write data held
		logic [ADDR_W-1:0] awaddr; // Captured write address
		logic [31:0] wdata; // Captured write data
		logic [3:0] wstrb; // Captured strobes
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic awready;
		logic wready;
		logic od; // Overdrive speed select
		logic active_pullup_enable; // Active pullup enable
		logic strong_pullup_enable; // Strong pullup enable, stored only
		logic busy; // Bus busy flag
		logic single_bit_result; // Single bit result
		logic triplet_second_bit; // Triplet second bit
		logic dirt; // Direction taken
		logic [7:0] rdreg; // Read data register
		logic [1:0] ptr; // Read pointer
		logic acked; // Last command acknowledged
		logic trip; // Running a triplet
		logic dirv; // Requested direction
		logic [3:0] slot; // Slot index
		logic wval; // Value driven in current slot
		logic [swrb_pkg::TW-1:0] tmr; // Cycle timer within slot
		logic line_out;
		logic line_oe;
		logic pu;
	} swrb_s_t;

	swrb_s_t s_reg;
	swrb_s_t s_next;

	// Timer ceilings picked by speed
	// Speed may only change between commands; a change mid-slot would
	// stretch or cut the slot in progress
	function automatic logic [swrb_pkg::TW-1:0] pick(input logic od, input int a, input int b);
		pick = od ? swrb_pkg::TW'(b) : swrb_pkg::TW'(a);
	endfunction

	logic [swrb_pkg::TW-1:0] t_slot; // Slot period in cycles
	logic [swrb_pkg::TW-1:0] t_low; // Initial low time
	logic [swrb_pkg::TW-1:0] t_w0; // Write-zero low time
	logic [swrb_pkg::TW-1:0] t_smp; // Sample point
	logic wr_fire; // Both write halves present
	logic [7:0] cmd_code; // Command byte of a write
	logic [7:0] cmd_par; // Parameter byte of a write

	// ----------------------------------------
	// Timer selection
	// ----------------------------------------
	// RULE_22 timers by speed
	// RULE_08 overdrive applies
	assign t_slot = pick(s_reg.od, swrb_pkg::STD_SLOT_CYC, swrb_pkg::OD_SLOT_CYC);
	assign t_low = pick(s_reg.od, swrb_pkg::STD_LOW_CYC, swrb_pkg::OD_LOW_CYC);
	assign t_w0 = pick(s_reg.od, swrb_pkg::STD_W0_CYC, swrb_pkg::OD_W0_CYC);
	assign t_smp = pick(s_reg.od, swrb_pkg::STD_SMP_CYC, swrb_pkg::OD_SMP_CYC);
	assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
	assign cmd_code = s_reg.wdata[7:0];
	assign cmd_par = s_reg.wdata[15:8];

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// Bus slave, command decode and slot sequencer together
	// Later assignments win: a bus handshake that completes in the same
	// cycle as a slot boundary is settled before the sequencer runs, and
	// the sequencer never writes a bus field, so neither masks the other
	always_comb begin
		logic first_bit; // Sampled result of read slot 0
		s_next = s_reg;
		first_bit = s_reg.single_bit_result;
		// Write channel capture, either order
		// Each half is held until both are present; the response then
		// blocks further capture until the host takes it
		if (s_reg.awready && s_axi_awvalid) begin
			s_next.aw_got = 1'b1;
			s_next.awaddr = s_axi_awaddr;
		end
		if (s_reg.wready && s_axi_wvalid) begin
			s_next.w_got = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		s_next.awready = !s_next.aw_got && !s_reg.bvalid;
		s_next.wready = !s_next.w_got && !s_reg.bvalid;
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
			s_next.awready = 1'b1;
			s_next.wready = 1'b1;
		end
		// Register write effects
		// A refused command still answers OKAY; only the ack register
		// tells the host that it was ignored
		if (wr_fire) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = swrb_pkg::RESP_OKAY;
			case (s_reg.awaddr)
				swrb_pkg::ADDR_CMD: begin
					if (s_reg.wstrb[0] && cmd_code == swrb_pkg::CMD_READ_BYTE) begin
						// RULE_03 refuse when busy
						s_next.acked = !s_reg.busy;
						if (!s_reg.busy) begin
							// RULE_01 start read byte
							s_next.trip = 1'b0;
							s_next.st = swrb_pkg::SW_WAIT;
							s_next.busy = 1'b1;
							s_next.slot = '0;
							s_next.tmr = '0;
							// RULE_06 pointer to status
							s_next.ptr = swrb_pkg::PTR_STATUS;
						end
					end else if (s_reg.wstrb[0] && s_reg.wstrb[1] &&
						cmd_code == swrb_pkg::CMD_TRIPLET) begin
						// RULE_14 refuse when busy
						s_next.acked = !s_reg.busy;
						if (!s_reg.busy) begin
							// RULE_09 start triplet
							s_next.trip = 1'b1;
							// RULE_20 only bit seven
							s_next.dirv = cmd_par[swrb_pkg::DIR_BIT];
							s_next.st = swrb_pkg::SW_WAIT;
							s_next.busy = 1'b1;
							s_next.slot = '0;
							s_next.tmr = '0;
							s_next.ptr = swrb_pkg::PTR_STATUS;
						end
					end else if (s_reg.wstrb[0] && cmd_code == swrb_pkg::CMD_SET_PTR) begin
						// Set read pointer: parameter bit picks data
						s_next.ptr = cmd_par[swrb_pkg::PTR_SEL_BIT] ? swrb_pkg::PTR_RDATA :
							swrb_pkg::PTR_STATUS;
						s_next.acked = 1'b1;
					end else begin
						s_next.acked = 1'b0;
						s_next.bresp = swrb_pkg::RESP_SLVERR;
					end
				end
				swrb_pkg::ADDR_CFG: begin
					if (s_reg.wstrb[0]) begin
						s_next.od = s_reg.wdata[swrb_pkg::CFG_OD];
						s_next.active_pullup_enable = s_reg.wdata[swrb_pkg::CFG_APU];
						s_next.strong_pullup_enable = s_reg.wdata[swrb_pkg::CFG_SPU];
					end
				end
				default: begin
					s_next.bresp = swrb_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Read channel
		// One read in flight: arready drops on the address handshake and
		// returns once the data has been taken
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		s_next.arready = !s_next.rvalid && !(s_reg.arready && s_axi_arvalid);
		if (s_reg.arready && s_axi_arvalid) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = swrb_pkg::RESP_OKAY;
			s_next.rdata = '0;
			case (s_axi_araddr)
				swrb_pkg::ADDR_CFG: begin
					s_next.rdata[swrb_pkg::CFG_OD] = s_reg.od;
					s_next.rdata[swrb_pkg::CFG_APU] = s_reg.active_pullup_enable;
					s_next.rdata[swrb_pkg::CFG_SPU] = s_reg.strong_pullup_enable;
				end
				swrb_pkg::ADDR_STATUS: begin
					s_next.rdata[swrb_pkg::ST_BUSY] = s_reg.busy;
					s_next.rdata[swrb_pkg::ST_SBR] = s_reg.single_bit_result;
					s_next.rdata[swrb_pkg::ST_TSB] = s_reg.triplet_second_bit;
					s_next.rdata[swrb_pkg::ST_DIR] = s_reg.dirt;
				end
				swrb_pkg::ADDR_RDATA: begin
					s_next.rdata[7:0] = s_reg.rdreg;
				end
				swrb_pkg::ADDR_PTR: begin
					s_next.rdata[1:0] = s_reg.ptr;
				end
				swrb_pkg::ADDR_ACK: begin
					s_next.rdata[0] = s_reg.acked;
				end
				default: begin
					s_next.rresp = swrb_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Slot sequencer
		// The timer counts cycles within a slot; release, sample point and
		// slot end are all compared against its next value so that each
		// event lands on exactly the cycle count named in the package
		case (s_reg.st)
			// Line released, pull-up off between commands
			swrb_pkg::SW_IDLE: begin
				s_next.line_oe = 1'b0;
				s_next.pu = 1'b0;
			end
			// One cycle from command to first low keeps the start early
			swrb_pkg::SW_WAIT: begin
				// RULE_05 start within bound
				// RULE_16 start within bound
				s_next.st = swrb_pkg::SW_SLOT;
				s_next.tmr = '0;
				s_next.wval = 1'b1;
				s_next.line_oe = 1'b1;
				s_next.line_out = 1'b0;
			end
			// Low phase, release, sample and slot end
			swrb_pkg::SW_SLOT: begin
				s_next.tmr = s_reg.tmr + 1'b1;
				// Release after low time; a zero holds longer
				// The pull-up may only assist once the line is let go
				if (s_reg.tmr + 1'b1 >= (s_reg.wval ? t_low : t_w0)) begin
					s_next.line_oe = 1'b0;
					// RULE_08 active pullup
					s_next.pu = s_reg.active_pullup_enable;
				end
				if (s_reg.tmr + 1'b1 == t_smp && s_reg.wval) begin
					if (!s_reg.trip) begin
						// RULE_21 lsb first shift
						// RULE_02 store sample
						s_next.rdreg = {line_in, s_reg.rdreg[7:1]};
					end else if (s_reg.slot == 4'h0) begin
						// RULE_18 first sample
						s_next.single_bit_result = line_in;
					end else if (s_reg.slot == 4'h1) begin
						// RULE_19 second sample
						s_next.triplet_second_bit = line_in;
						first_bit = s_reg.single_bit_result;
						// RULE_10 both zero
						// RULE_11 zero then one
						// RULE_12 one then zero
						// RULE_13 both one
						if (first_bit == line_in) begin
							s_next.dirt = first_bit ? 1'b1 : s_reg.dirv;
						end else begin
							s_next.dirt = first_bit;
						end
					end
				end
				if (s_reg.tmr + 1'b1 >= t_slot) begin
					s_next.tmr = '0;
					s_next.slot = s_reg.slot + 1'b1;
					// RULE_04 eight slots
					// RULE_15 three slots
					if ((!s_reg.trip && s_reg.slot == 4'(swrb_pkg::NBITS_BYTE - 1)) ||
						(s_reg.trip && s_reg.slot == 4'(swrb_pkg::TRIP_SLOTS - 1))) begin
						s_next.st = swrb_pkg::SW_DONE;
						s_next.pu = 1'b0;
					end else begin
						s_next.line_oe = 1'b1;
						s_next.line_out = 1'b0;
						s_next.pu = 1'b0;
						// Write slot value from direction taken
						// Direction was settled at the second sample, well before this
						s_next.wval = (s_reg.trip && s_reg.slot == 4'h1) ? s_next.dirt : 1'b1;
					end
				end
			end
			// Busy drops one cycle after the last slot
			swrb_pkg::SW_DONE: begin
				// RULE_07 busy for eight slots
				// RULE_17 busy for three slots
				s_next.busy = 1'b0;
				s_next.st = swrb_pkg::SW_IDLE;
			end
			// Stray state code: back to idle
			default: begin
				s_next.st = swrb_pkg::SW_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Async reset to constants only
	// Ready flags come up high so the first request can be taken at the
	// first edge after release
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_reg <= '0;
			s_reg.st <= swrb_pkg::SW_IDLE;
			s_reg.awready <= 1'b1;
			s_reg.wready <= 1'b1;
			s_reg.arready <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs straight from flops
	// No logic between the record and the pins, so no output glitches
	// ----------------------------------------
	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign line_out = s_reg.line_out;
	assign line_oe = s_reg.line_oe;
	assign pullup_active = s_reg.pu;
endmodule

// ### sim/swrb_monitor.sv
// Checker for the read-byte and triplet engine, watching its ports only.
// Assumes one clock domain and the bus and line ports of swrb_engine.
`timescale 1ns/1ns
module swrb_monitor #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic line_out,
	input wire logic line_oe,
	input wire logic pullup_active
);
	int idle_cnt; // Cycles since line last driven
	int low_cnt; // Length of current low
	// ----
	// Helper counters; idle saturates so a quiet line means not busy
	// ----
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			idle_cnt <= 2047;
			low_cnt <= 0;
		end else begin
			idle_cnt <= line_oe ? 0 : (idle_cnt < 2047 ? idle_cnt + 1 : idle_cnt);
			low_cnt <= line_oe ? low_cnt + 1 : 0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Address and data taken together
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// A line command reaches the command register
	sequence s_cmd;
		s_wr ##0 (s_axi_awaddr == swrb_pkg::ADDR_CMD) && (s_axi_wdata[7:0] ==
			swrb_pkg::CMD_READ_BYTE || s_axi_wdata[7:0] == swrb_pkg::CMD_TRIPLET);
	endsequence
	a_line_start: assert property (s_cmd ##0 idle_cnt > 1500 |-> ##[1:6] line_oe)
		else $error("line activity late");
	a_b_answer: assert property (s_wr |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_pullup_off: assert property (pullup_active |-> !line_oe)
		else $error("pullup while pulling low");
	a_low_min: assert property ($rose(line_oe) |-> line_oe [*8] ##0 !line_out)
		else $error("slot low too short");
	a_low_max: assert property (low_cnt <= 1210)
		else $error("slot low too long");
endmodule
bind swrb_engine swrb_monitor #(.ADDR_W(ADDR_W)) swrb_monitor_i (.clk(clk), .reset(reset),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .line_out(line_out),
	.line_oe(line_oe), .pullup_active(pullup_active));

// ### sim/swrb_slave.sv
// Behavioural single-wire slave answering read slots from a byte.
// Assumes an open-drain line with pull-up, resolved in the bench.
`timescale 1ns/1ns
module swrb_slave (
	input wire logic clk,
	input wire logic reset,
	input wire logic line_oe,
	input wire logic line_out,
	input wire logic fast,
	input wire logic tx_load,
	input wire logic [7:0] tx_bits,
	output logic slave_pull,
	output logic wr_bit
);
	logic drv; // Master pulls low now
	logic drv_d; // Previous master drive
	int idx; // Next bit to answer
	int hold; // Remaining hold of our low
	int len; // Length of master low
	assign drv = line_oe & !line_out;
	// ----
	// Slot tracking from the master's falling edge
	// ----
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			drv_d <= 0;
			idx <= 0;
			hold <= 0;
			len <= 0;
			slave_pull <= 0;
			wr_bit <= 1;
		end else begin
			drv_d <= drv;
			if (tx_load)
				idx <= 0;
			if (drv && !drv_d) begin
				hold <= fast ? 80 : 600;
				slave_pull <= !tx_bits[idx[2:0]];
				idx <= idx + 1;
			end else if (hold > 1)
				hold <= hold - 1;
			else
				slave_pull <= 0;
			// Long master low past the sample point means a zero written
			if (drv)
				len <= len + 1;
			else if (drv_d) begin
				wr_bit <= len <= (fast ? 40 : 300);
				len <= 0;
			end
		end
	end
endmodule

// ### sim/tb_top.sv
// Top testbench: AXI4-Lite master, slave model and result checks.
// Assumes the engine, its package and the checker bind are compiled.
`timescale 1ns/1ns
module tb_top;
	logic clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0, tx_bits = 8'hff;
	logic [31:0] wdata = 0, rdata;
	logic awready, wready, bvalid, arready, rvalid, line_out, line_oe, pullup_active, line_in;
	logic [1:0] bresp, rresp;
	logic fast = 0, tx_load = 0, slave_pull, wr_bit;
	int error_cnt = 0, comparisons = 0, cyc = 0, seed = 32'hfccd316b, pu_cyc = 0;
	// Open-drain line with pull-up
	assign line_in = !((line_oe & !line_out) | slave_pull);
	always #25 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	// Cycles with the active pull-up on
	always @(posedge clk) begin
		if (pullup_active) pu_cyc <= pu_cyc + 1;
	end
	swrb_engine swrb_engine_i (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe), .pullup_active(pullup_active));
	swrb_slave swrb_slave_i (.clk(clk), .reset(reset), .line_oe(line_oe), .line_out(line_out),
		.fast(fast), .tx_load(tx_load), .tx_bits(tx_bits), .slave_pull(slave_pull),
		.wr_bit(wr_bit));
	// ----
	// Bus tasks, checks and expectations
	// ----
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task test_done;
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Waits as long as the answer takes; only the watchdog ends a hang
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		r = 2'h3;
		done = 0;
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid && bready) begin
				r = bresp;
				bready <= 0;
				done = 1;
			end
		end
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		done = 0;
		while (!done) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 0;
				done = 1;
			end
		end
	endtask
	// Written slot of a triplet from both reads and the direction
	function logic twrite(logic b1, logic b2, logic v);
		return (b1 == b2) ? (b1 | v) : b1;
	endfunction
	// One command, refusals while busy, then poll until idle
	task run(input logic [31:0] d, input int slots);
		int t0, sl;
		logic [31:0] s;
		logic [1:0] r;
		sl = fast ? swrb_pkg::OD_SLOT_CYC : swrb_pkg::STD_SLOT_CYC;
		tx_load <= 1;
		@(posedge clk);
		tx_load <= 0;
		wr(8'h00, d, r);
		t0 = cyc;
		rd(8'h14, s, r);
		chk("ack", 1, s);
		wr(8'h00, 32'h8078, r);
		rd(8'h14, s, r);
		chk("busy triplet ack", 0, s);
		wr(8'h00, 32'h96, r);
		rd(8'h14, s, r);
		chk("busy read ack", 0, s);
		do begin
			rd(8'h08, s, r);
		end while (s[0] !== 1'b0);
		chk("busy span", 1, cyc - t0 >= slots * sl && cyc - t0 <= slots * sl + 16);
		rd(8'h10, s, r);
		chk("pointer", 0, s);
	endtask
	// ----
	// Main sequence and watchdog
	// ----
	initial begin
		logic [31:0] s;
		logic [1:0] r;
		logic [7:0] b;
		int p0;
		repeat (16) @(posedge clk);
		reset <= 0;
		rd(8'h1c, s, r);
		chk("unmapped read", 2, r);
		wr(8'h1c, 32'h0, r);
		chk("unmapped write", 2, r);
		wr(8'h04, 32'h3, r);
		fast <= 1;
		rd(8'h04, s, r);
		chk("config", 3, s);
		for (int i = 0; i < 8; i++) begin
			b = 8'($random(seed));
			tx_bits <= {6'h3f, i[1], i[0]};
			run({16'h0, i[2], b[6:0], 8'h78}, 3);
			rd(8'h08, s, r);
			chk("status", {twrite(i[0], i[1], i[2]), i[1], i[0], 5'h0}, s);
			chk("write slot", twrite(i[0], i[1], i[2]), wr_bit);
		end
		chk("pullup used", 1, pu_cyc > 0);
		for (int k = 0; k < 2; k++) begin
			if (k == 1) begin
				wr(8'h04, 32'h0, r);
				fast <= 0;
				repeat (1600) @(posedge clk);
				p0 = pu_cyc;
			end
			b = 8'($random(seed));
			tx_bits <= b;
			run(32'h96, 8);
			if (k == 1)
				chk("pullup off", p0, pu_cyc);
			wr(8'h00, 32'h1e1, r);
			rd(8'h10, s, r);
			chk("pointer set", 1, s);
			rd(8'h0c, s, r);
			chk("read data", b, s);
		end
		test_done;
	end
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		test_done;
	end
endmodule
